// ===== verilog/rpsel_top.sv
/*
 Remappable pin select with write protection, shadow monitoring and
 an interrupt on protection events.
 Assumes an Avalon-MM master on clk_sys, peripheral outputs on
 clk_sys, and asynchronous pad inputs that are synchronised here.
*/
`timescale 1ns/1ps

// What this block does
// - Each functional input takes one pin; each pin takes one function.
// - One pin may feed many inputs; one function may drive many pins.
// - Fields address 64 pins; at most 44 exist, 12 input-only.
// - Input selection of absent pin or above 43 leaves input unconnected.
// - Output fields of absent pins are not stored; writes ignored.
// - Locked mapping writes complete normally but change nothing.
// - Lock bit 6 of oscillator control blocks mapping writes when set.
// - Lock bit holds until changed by the unlock sequence.
// - Shadows track mapping registers; a difference raises mismatch reset.
// - With one-way option set, a set lock cannot be cleared.
// - Under one-way option only device reset clears the lock.
// - One-way option unprogrammed is set: a single write session.
// - Available pins depend on package: 64, 80 or 100 pins.
// - Output register holds fields at bits 13-8 and 5-0.
module rpsel_top #(
   parameter int PIN_COUNT = 100
)(
   // Clock and reset
   input  wire logic                          clk_sys,
   input  wire logic                          rst,
   // Avalon-MM slave
   input  wire logic [7:0]                    address,
   input  wire logic                          read,
   input  wire logic                          write,
   input  wire logic [31:0]                   writedata,
   input  wire logic [3:0]                    byteenable,
   output      logic [31:0]                   readdata,
   output      logic                          waitrequest,
   // Configuration word option and system reset request
   input  wire logic                          one_way_lock_cfg,
   output      logic                          cfg_mismatch_rst,
   output      logic                          irq,
   // Pads
   input  wire logic [rpsel_pkg::N_PIN-1:0]   remap_pin_i,
   output      logic [rpsel_pkg::N_RP-1:0]    remap_pin_o,
   output      logic [rpsel_pkg::N_RP-1:0]    remap_pin_oe_n,
   // Peripheral side
   input  wire logic [rpsel_pkg::N_OUT_FN-1:0] periph_out,
   output      logic [rpsel_pkg::N_IN_FN-1:0]  periph_in
);
   logic [rpsel_pkg::N_REG-1:0][15:0]    map_r;
   logic [rpsel_pkg::N_REG-1:0][15:0]    shadow_r;
   logic [rpsel_pkg::N_PIN-1:0]          sync1_r;
   logic [rpsel_pkg::N_PIN-1:0]          sync2_r;
   logic [rpsel_pkg::N_IN_FN-1:0]        periph_in_r;
   logic [rpsel_pkg::N_RP-1:0]           pin_o_r;
   logic [rpsel_pkg::N_RP-1:0]           pin_oe_n_r;
   logic [rpsel_pkg::ST_W-1:0]           stat_r;
   logic [rpsel_pkg::ST_W-1:0]           stat_nxt;
   logic [rpsel_pkg::ST_W-1:0]           mask_r;
   logic [31:0]                          rdata_r;
   logic                                 ack_r;
   logic                                 lock_r;
   logic                                 lock_nxt;
   logic                                 one_way_r;
   logic                                 mismatch_r;
   rpsel_pkg::rpsel_seq_e                seq_r;
   rpsel_pkg::rpsel_seq_e                seq_nxt;
   logic [5:0]                           in_fld  [rpsel_pkg::N_IN_FN];
   logic [5:0]                           out_fld [rpsel_pkg::N_RP];

   // Package variant selects which pin numbers exist
   wire [63:0] impl = (PIN_COUNT == 64) ? rpsel_pkg::IMPL_64 :
                      (PIN_COUNT == 80) ? rpsel_pkg::IMPL_80 :
                                          rpsel_pkg::IMPL_100;

   // Avalon handshake: one wait cycle, answer on the second
   wire        req     = read | write;
   wire        wr_go   = write & ack_r;
   wire        rd_go   = read & ack_r;
   wire        acc_go  = wr_go | rd_go;
   assign waitrequest  = req & ~ack_r;
   assign readdata     = rdata_r;

   // Address decode
   wire        osc_hit  = (address == rpsel_pkg::OFS_OSC);
   wire        stat_hit = (address == rpsel_pkg::OFS_STAT);
   wire        mask_hit = (address == rpsel_pkg::OFS_MASK);
   wire        in_hit   = (address[7:4] == rpsel_pkg::IN_BASE_HI) &&
                          (address[1:0] == 2'h0);
   wire        out_hit  = (address[7:6] == rpsel_pkg::OUT_BASE_HI) &&
                          (address[1:0] == 2'h0);
   wire        map_hit  = in_hit | out_hit;
   wire [3:0]  out_pair = address[5:2];
   wire [4:0]  map_idx  = in_hit ? {3'h0, address[3:2]}
                                 : 5'(5'd4 + {1'b0, out_pair});

   // Absent output pins keep their fields at zero
   wire [15:0] out_wmask = {2'h0, {6{impl[{out_pair, 1'b1}]}},
                            2'h0, {6{impl[{out_pair, 1'b0}]}}};
   wire [15:0] wmask     = (in_hit ? rpsel_pkg::IN_WMASK : out_wmask) &
                           {{8{byteenable[1]}}, {8{byteenable[0]}}};
   wire [15:0] map_new   = (map_r[map_idx] & ~wmask) |
                           (writedata[15:0] & wmask);

   // Locked writes are acknowledged but dropped
   wire        map_we    = wr_go & map_hit & ~lock_r;
   wire        blocked   = wr_go & map_hit & lock_r;

   // Unlock sequence decode
   wire        osc_wr_lo = wr_go & osc_hit & byteenable[0];
   wire        key_one   = osc_wr_lo &
                           (writedata[7:0] == rpsel_pkg::KEY_ONE);
   wire        key_two   = osc_wr_lo &
                           (writedata[7:0] == rpsel_pkg::KEY_TWO);
   wire        lock_wr   = osc_wr_lo & (seq_r == rpsel_pkg::SQ_KEY2);
   // One-way option freezes a set lock until device reset
   wire        lock_frz  = one_way_r & lock_r;

   // Read mux; unmapped addresses read zero
   wire [31:0] osc_rd  = 32'(lock_r) << rpsel_pkg::LOCK_BIT;
   wire [31:0] rd_mux  =
      osc_hit  ? osc_rd :
      stat_hit ? {29'h0, stat_r} :
      mask_hit ? {29'h0, mask_r} :
      map_hit  ? {16'h0, map_r[map_idx]} : 32'h0;

   // Interrupt: sticky events gated by mask
   assign irq = |(stat_r & mask_r);

   // Bus acknowledge and read data
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         ack_r   <= 1'b0;
         rdata_r <= 32'h0;
      end
      else
      begin
         ack_r   <= req & ~ack_r;
         rdata_r <= (read & ~ack_r) ? rd_mux : rdata_r;
      end
   end

   // Unlock FSM; any other completed access aborts, but a repeated first key holds the first-key state
   always_comb
   begin
      seq_nxt = seq_r;
      if (acc_go)
      begin
         case (seq_r)
            rpsel_pkg::SQ_IDLE:
               seq_nxt = key_one ? rpsel_pkg::SQ_KEY1 : rpsel_pkg::SQ_IDLE;
            rpsel_pkg::SQ_KEY1:
               seq_nxt = key_two ? rpsel_pkg::SQ_KEY2 :
                         key_one ? rpsel_pkg::SQ_KEY1 : rpsel_pkg::SQ_IDLE;
            rpsel_pkg::SQ_KEY2:
               seq_nxt = rpsel_pkg::SQ_IDLE;
            default:
               seq_nxt = rpsel_pkg::SQ_IDLE;
         endcase
      end
   end

   // Lock keeps its state between sessions
   assign lock_nxt = (lock_wr && !lock_frz) ?
                     writedata[rpsel_pkg::LOCK_BIT] : lock_r;

   // Lock resets clear; option latched while reset is held
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         seq_r     <= rpsel_pkg::SQ_IDLE;
         lock_r    <= 1'b0;
         one_way_r <= one_way_lock_cfg;
      end
      else
      begin
         seq_r     <= seq_nxt;
         lock_r    <= lock_nxt;
      end
   end

   // Mapping registers and their shadows written together
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         for (int i = 0; i < rpsel_pkg::N_REG; i++)
         begin
            map_r[i]    <= (i < rpsel_pkg::N_IN_REG) ?
                           rpsel_pkg::IN_RST : rpsel_pkg::OUT_RST;
            shadow_r[i] <= (i < rpsel_pkg::N_IN_REG) ?
                           rpsel_pkg::IN_RST : rpsel_pkg::OUT_RST;
         end
      end
      else if (map_we)
      begin
         map_r[map_idx]    <= map_new;
         shadow_r[map_idx] <= map_new;
      end
   end

   // Any divergence from shadow requests a mismatch reset
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         mismatch_r <= 1'b0;
      else
         mismatch_r <= (map_r != shadow_r);
   end
   assign cfg_mismatch_rst = mismatch_r;

   // Sticky status: a new event wins over a same-cycle clear
   always_comb
   begin
      stat_nxt = stat_r;
      if (wr_go && stat_hit && byteenable[0])
         stat_nxt = stat_r & ~writedata[rpsel_pkg::ST_W-1:0];
      stat_nxt[rpsel_pkg::ST_MISMATCH] =
         stat_nxt[rpsel_pkg::ST_MISMATCH] | mismatch_r;
      stat_nxt[rpsel_pkg::ST_LOCKCHG]  =
         stat_nxt[rpsel_pkg::ST_LOCKCHG] | (lock_nxt != lock_r);
      stat_nxt[rpsel_pkg::ST_BLOCKED]  =
         stat_nxt[rpsel_pkg::ST_BLOCKED] | blocked;
   end

   // Status and mask registers
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         stat_r <= '0;
         mask_r <= '0;
      end
      else
      begin
         stat_r <= stat_nxt;
         if (wr_go && mask_hit && byteenable[0])
            mask_r <= writedata[rpsel_pkg::ST_W-1:0];
      end
   end

   // Field views of the mapping registers
   genvar g;
   generate
      for (g = 0; g < rpsel_pkg::N_IN_FN; g++)
      begin : g_in
         assign in_fld[g] = (g % 2 == 1) ?
            map_r[g/2][rpsel_pkg::FLD_HI +: rpsel_pkg::FLD_W] :
            map_r[g/2][rpsel_pkg::FLD_LO +: rpsel_pkg::FLD_W];
      end
      for (g = 0; g < rpsel_pkg::N_RP; g++)
      begin : g_out
         assign out_fld[g] = (g % 2 == 1) ?
            map_r[rpsel_pkg::N_IN_REG + g/2]
                 [rpsel_pkg::FLD_HI +: rpsel_pkg::FLD_W] :
            map_r[rpsel_pkg::N_IN_REG + g/2]
                 [rpsel_pkg::FLD_LO +: rpsel_pkg::FLD_W];
      end
   endgenerate

   // Pad synchroniser; only the second stage is read
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         sync1_r <= '0;
         sync2_r <= '0;
      end
      else
      begin
         sync1_r <= remap_pin_i;
         sync2_r <= sync1_r;
      end
   end

   // Zero-extended views so any 6-bit selector indexes safely
   wire [63:0] pin_vec = {20'h0, sync2_r};
   wire [63:0] fn_vec  = {47'h0, periph_out, 1'b0};

   // Each input takes exactly one pin, so no contention
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         periph_in_r <= '0;
      else
         for (int k = 0; k < rpsel_pkg::N_IN_FN; k++)
            periph_in_r[k] <= (in_fld[k] <= rpsel_pkg::MAX_PIN_SEL) &&
                              impl[in_fld[k]] && pin_vec[in_fld[k]];
   end
   assign periph_in = periph_in_r;

   // Each pin takes exactly one function; zero releases it
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         pin_o_r    <= '0;
         pin_oe_n_r <= '1;
      end
      else
         for (int p = 0; p < rpsel_pkg::N_RP; p++)
         begin
            pin_o_r[p]    <= fn_vec[out_fld[p]];
            pin_oe_n_r[p] <= (out_fld[p] == 6'h0) ||
                             (out_fld[p] > 6'(rpsel_pkg::N_OUT_FN));
         end
   end
   assign remap_pin_o    = pin_o_r;
   assign remap_pin_oe_n = pin_oe_n_r;

   // Checks
   property p_locked_write;
      @(posedge clk_sys) disable iff (rst)
      (wr_go && map_hit && lock_r) |=> $stable(map_r);
   endproperty
   a_locked_write: assert property (p_locked_write)
      else $error("locked mapping write changed a register");
   property p_open_write;
      @(posedge clk_sys) disable iff (rst)
      (wr_go && in_hit && !lock_r && byteenable[1:0] == 2'h3) |=>
         map_r[$past(map_idx)] == ($past(writedata[15:0]) &
                                   rpsel_pkg::IN_WMASK);
   endproperty
   a_open_write: assert property (p_open_write)
      else $error("unlocked input map write not stored");
   property p_invalid_sel;
      @(posedge clk_sys) disable iff (rst)
      (in_fld[0] > rpsel_pkg::MAX_PIN_SEL) |=> !periph_in[0];
   endproperty
   a_invalid_sel: assert property (p_invalid_sel)
      else $error("invalid pin selection connected an input");
   property p_lock_hold;
      @(posedge clk_sys) disable iff (rst)
      !(osc_wr_lo && seq_r == rpsel_pkg::SQ_KEY2) |=> $stable(lock_r);
   endproperty
   a_lock_hold: assert property (p_lock_hold)
      else $error("lock changed outside the unlock sequence");
   property p_one_way;
      @(posedge clk_sys) disable iff (rst)
      (one_way_r && lock_r) |=> lock_r [*3];
   endproperty
   a_one_way: assert property (p_one_way)
      else $error("one-way lock was cleared");
   property p_abort;
      @(posedge clk_sys) disable iff (rst)
      rd_go |=> (seq_r == rpsel_pkg::SQ_IDLE) ##1 $stable(lock_r);
   endproperty
   a_abort: assert property (p_abort)
      else $error("read did not abort the unlock sequence");
   property p_mismatch;
      @(posedge clk_sys) disable iff (rst)
      (map_r != shadow_r) |=> cfg_mismatch_rst ##1
         stat_r[rpsel_pkg::ST_MISMATCH];
   endproperty
   a_mismatch: assert property (p_mismatch)
      else $error("shadow difference not reported");
   property p_absent_out;
      @(posedge clk_sys) disable iff (rst)
      !impl[5] |-> (out_fld[5] == 6'h0 && remap_pin_oe_n[5]);
   endproperty
   a_absent_out: assert property (p_absent_out)
      else $error("absent output pin field not zero");
endmodule

// ===== verilog/rpsel_pkg.sv
/*
 Constants for the remappable pin select block: register map, field
 layout, reset values, key bytes, pin-availability masks.
 Assumes a 16-bit register image placed in the low half of each
 32-bit Avalon word.
*/
package rpsel_pkg;
   // Byte offsets on the register bus
   localparam logic [7:0] OFS_OSC     = 8'h00;
   localparam logic [7:0] OFS_STAT    = 8'h04;
   localparam logic [7:0] OFS_MASK    = 8'h08;
   localparam logic [3:0] IN_BASE_HI  = 4'h4;   // 0x40..0x4c
   localparam logic [1:0] OUT_BASE_HI = 2'h2;   // 0x80..0xbc

   // Register counts and field layout
   localparam int         N_IN_REG    = 4;
   localparam int         N_OUT_REG   = 16;
   localparam int         N_REG       = N_IN_REG + N_OUT_REG;
   localparam int         N_IN_FN     = 2 * N_IN_REG;
   localparam int         N_OUT_FN    = 16;
   localparam int         N_RP        = 2 * N_OUT_REG;
   localparam int         N_PIN       = 44;
   localparam int         FLD_W       = 6;
   localparam int         FLD_LO      = 0;
   localparam int         FLD_HI      = 8;
   localparam int         LOCK_BIT    = 6;
   localparam logic [5:0] MAX_PIN_SEL = 6'h2b;  // 43

   // Reset values and implemented-bit masks
   localparam logic [15:0] IN_RST     = 16'h3f3f;
   localparam logic [15:0] OUT_RST    = 16'h0000;
   localparam logic [15:0] IN_WMASK   = 16'h3f3f;

   // Unlock keys, written to the low byte of the oscillator control
   localparam logic [7:0] KEY_ONE     = 8'h46;
   localparam logic [7:0] KEY_TWO     = 8'h57;

   // Status / mask bit positions
   localparam int         ST_MISMATCH = 0;
   localparam int         ST_LOCKCHG  = 1;
   localparam int         ST_BLOCKED  = 2;
   localparam int         ST_W        = 3;

   // Implemented pin numbers per package pin count
   localparam logic [63:0] IMPL_64    = 64'h0000_0020_3fff_7fdf;
   localparam logic [63:0] IMPL_80    = 64'h0000_0d7e_7fff_ffff;
   localparam logic [63:0] IMPL_100   = 64'h0000_0fff_ffff_ffff;

   typedef enum logic [2:0]
   {
      SQ_IDLE = 3'b001,
      SQ_KEY1 = 3'b010,
      SQ_KEY2 = 3'b100
   } rpsel_seq_e;
endpackage

// ===== verif/tb.sv
/*
 Self-checking bench for the remappable pin select block, 64-pin build.
 Assumes the design package is compiled first; drives the Avalon slave,
 pads and peripheral outputs directly, with no partner model.
*/
`timescale 1ns/1ps

module tb;
   // Clock, reset and configuration option
   logic                            clk_sys;
   logic                            rst;
   logic                            one_way_lock_cfg;
   // Avalon master side
   logic [7:0]                      address;
   logic                            read;
   logic                            write;
   logic [31:0]                     writedata;
   logic [3:0]                      byteenable;
   logic [31:0]                     readdata;
   logic                            waitrequest;
   // Block outputs and pads
   logic                            cfg_mismatch_rst;
   logic                            irq;
   logic [rpsel_pkg::N_PIN-1:0]     remap_pin_i;
   logic [rpsel_pkg::N_RP-1:0]      remap_pin_o;
   logic [rpsel_pkg::N_RP-1:0]      remap_pin_oe_n;
   logic [rpsel_pkg::N_OUT_FN-1:0]  periph_out;
   logic [rpsel_pkg::N_IN_FN-1:0]   periph_in;
   // Bench bookkeeping
   int                              err_count;
   int                              checked;
   logic [31:0]                     rd_val;

   // Smallest package, so absent pins can be exercised
   rpsel_top #(.PIN_COUNT(64)) i_rpsel_top (
      .clk_sys(clk_sys), .rst(rst), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(byteenable),
      .readdata(readdata), .waitrequest(waitrequest),
      .one_way_lock_cfg(one_way_lock_cfg),
      .cfg_mismatch_rst(cfg_mismatch_rst), .irq(irq),
      .remap_pin_i(remap_pin_i), .remap_pin_o(remap_pin_o),
      .remap_pin_oe_n(remap_pin_oe_n), .periph_out(periph_out),
      .periph_in(periph_in));

   // 10 MHz system clock
   initial
   begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   task automatic conclude();
      $display("errors %0d, comparisons %0d", err_count, checked);
      if (err_count == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("mismatch at %0t: got %h exp %h", $time, got, exp);
      end
   endtask

   // Samples waitrequest at each rising edge; data taken at the rising edge that sees it low
   task automatic wait_ack();
      int n;
      n = 0;
      @(posedge clk_sys);
      while (waitrequest !== 1'b0 && n < 50)
      begin
         @(posedge clk_sys);
         n++;
      end
      if (waitrequest !== 1'b0)
      begin
         err_count++;
         $display("mismatch at %0t: no bus answer", $time);
      end
      rd_val = readdata;
   endtask

   // One write; leaves an idle cycle so strobes never retrigger at once
   task automatic bus_wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      address   <= a;
      writedata <= {16'h0000, d};
      write     <= 1'b1;
      wait_ack();
      write     <= 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
      @(posedge clk_sys);
      address <= a;
      read    <= 1'b1;
      wait_ack();
      read    <= 1'b0;
      chk(rd_val, {16'h0000, exp});
   endtask

   // Keys then the lock write, on consecutive accesses
   task automatic unlock(input logic lk);
      bus_wr(rpsel_pkg::OFS_OSC, {8'h00, rpsel_pkg::KEY_ONE});
      bus_wr(rpsel_pkg::OFS_OSC, {8'h00, rpsel_pkg::KEY_TWO});
      bus_wr(rpsel_pkg::OFS_OSC, lk ? 16'h0040 : 16'h0000);
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask

   task automatic do_reset(input logic cfg);
      @(posedge clk_sys);
      one_way_lock_cfg <= cfg;
      rst              <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rst              <= 1'b0;
   endtask

   task automatic t_reset();
      rd_chk(8'h40, 16'h3f3f);
      rd_chk(8'h80, 16'h0000);
      rd_chk(8'h00, 16'h0000);
      bus_wr(8'h0c, 16'hffff);
      rd_chk(8'h0c, 16'h0000);
      chk(32'(periph_in), 32'h0);
      chk(32'(remap_pin_oe_n), 32'hffff_ffff);
   endtask

   // Function 1 on pins 0 and 1; pin 5 is absent on the small package
   task automatic t_outmap();
      periph_out <= 16'h0005;
      bus_wr(8'h80, 16'h0101);
      bus_wr(8'h88, 16'h0303);
      rd_chk(8'h88, 16'h0003);
      settle(2);
      chk(32'(remap_pin_o[1:0]), 32'h3);
      chk(32'(remap_pin_oe_n[5:0]), 32'h2c);
      chk(32'(remap_pin_o[4]), 32'h1);
   endtask

   task automatic t_inmap();
      remap_pin_i <= '0;
      bus_wr(8'h40, 16'h0606);
      remap_pin_i[6] <= 1'b1;
      settle(4);
      chk(32'(periph_in[1:0]), 32'h3);
      bus_wr(8'h40, 16'h2c05);
      rd_chk(8'h40, 16'h2c05);
      remap_pin_i <= '1;
      settle(4);
      chk(32'(periph_in[1:0]), 32'h0);
      bus_wr(8'h40, 16'h2c25);
      settle(4);
      chk(32'(periph_in[1:0]), 32'h1);
   endtask

   task automatic t_lock();
      unlock(1'b1);
      rd_chk(8'h00, 16'h0040);
      rd_chk(8'h04, 16'h0002);
      bus_wr(8'h08, 16'h0004);
      bus_wr(8'h80, 16'h0202);
      rd_chk(8'h80, 16'h0101);
      rd_chk(8'h04, 16'h0006);
      chk(32'(irq), 32'h1);
      bus_wr(8'h04, 16'h0004);
      @(negedge clk_sys);
      chk(32'(irq), 32'h0);
      unlock(1'b0);
      rd_chk(8'h00, 16'h0000);
      bus_wr(8'h80, 16'h0202);
      bus_wr(8'h88, 16'h0101);
      rd_chk(8'h80, 16'h0202);
      rd_chk(8'h88, 16'h0001);
      chk(32'(cfg_mismatch_rst), 32'h0);
   endtask

   // A read between the keys must spoil the sequence
   task automatic t_abort();
      bus_wr(8'h00, 16'h0046);
      rd_chk(8'h00, 16'h0000);
      bus_wr(8'h00, 16'h0057);
      bus_wr(8'h00, 16'h0040);
      rd_chk(8'h00, 16'h0000);
   endtask

   task automatic t_oneway();
      do_reset(1'b1);
      unlock(1'b1);
      unlock(1'b0);
      rd_chk(8'h00, 16'h0040);
      bus_wr(8'h80, 16'h0005);
      rd_chk(8'h80, 16'h0000);
      do_reset(1'b1);
      rd_chk(8'h00, 16'h0000);
      bus_wr(8'h80, 16'h0005);
      rd_chk(8'h80, 16'h0005);
      chk(32'(cfg_mismatch_rst), 32'h0);
   endtask

   // Stimulus: plenty of margin over the fewer than two hundred cycles needed
   initial
   begin
      err_count        = 0;
      checked          = 0;
      rst              = 1'b1;
      one_way_lock_cfg = 1'b0;
      address          = 8'h00;
      read             = 1'b0;
      write            = 1'b0;
      writedata        = 32'h0000_0000;
      byteenable       = 4'h3;
      remap_pin_i      = '0;
      periph_out       = '0;
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      t_reset();
      t_outmap();
      t_inmap();
      t_lock();
      t_abort();
      t_oneway();
      conclude();
   end

   // Watchdog cuts a hang short
   initial
   begin
      #2000000;
      err_count++;
      conclude();
   end
endmodule
